// ---- verilog/hbsc_serial_ctrl.sv ----
`timescale 1ns/1ps
module hbsc_serial_ctrl #(
	parameter int UV_FILTER_CYC = hbsc_pkg::UV_FILTER_CYC
) (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  sclk,
	input  wire logic                  cs_n,
	input  wire logic                  serial_in,
	output logic                       serial_out,
	output logic                       serial_out_en,
	input  wire logic                  run_enable,
	input  wire logic                  thermal_warning_in,
	input  wire logic                  uv_in,
	input  wire hbsc_pkg::hbsc_switch_t short_in,
	input  wire hbsc_pkg::hbsc_switch_t open_load_in,
	output hbsc_pkg::hbsc_switch_t      switch_on,
	output logic                       overcurrent_cutoff_en,
	output logic                       test_mode
);

	// Reserved test-mode words; any other word runs normally
	function automatic logic is_test_word(input logic [15:0] w);
		is_test_word = (w == hbsc_pkg::TEST_PAT_A) ||
			(w == hbsc_pkg::TEST_PAT_B) ||
			(w == hbsc_pkg::TEST_PAT_C);
	endfunction

	// A zero delay would let every supply dip through unfiltered
	generate
		if (UV_FILTER_CYC < 1)
		begin : g_bad_filter
			$error("hbsc_serial_ctrl: filter delay must be at least one cycle");
		end
	endgenerate

	// Link side, clocked by sclk
	logic                           link_clr;       // Deselect or reset clears link counters
	logic [hbsc_pkg::CNT_W-1:0]     rx_cnt_reg;     // Bits sampled in this frame
	logic [hbsc_pkg::CNT_W-1:0]     tx_cnt_reg;     // Rising edges seen in this frame
	logic [15:0]                    rx_shift_reg;   // Incoming bits, newest at the top
	logic [15:0]                    rx_word_next;   // Shift register after this edge
	hbsc_pkg::hbsc_ctrl_t           word_hold_reg;  // Last complete word, read by core
	logic                           done_tgl_reg;   // Flips once per complete word
	logic [3:0]                     tx_idx;         // Status bit on the serial output

	// Core side, clocked by core_clk
	logic [hbsc_pkg::SYNC_W-1:0]    sync_in;        // Raw pins and link toggle
	logic [hbsc_pkg::SYNC_W-1:0]    sync_q;         // Their agreed values
	logic                           cs_q;           // Chip select, high when idle
	logic                           run_q;          // Run-enable level
	logic                           done_q;         // Link word toggle
	logic                           therm_q;        // Thermal warning level
	logic                           uv_raw_q;       // Unfiltered undervoltage
	logic [5:0]                     short_q;        // Per-switch overcurrent
	logic [5:0]                     open_q;         // Per-switch undercurrent
	logic                           uv_q;           // Qualified undervoltage
	logic                           cs_prev_reg;    // Chip select one cycle ago
	logic                           done_prev_reg;  // Toggle one cycle ago
	logic                           pending_reg;    // A full word arrived this frame
	logic                           cs_fall;        // Frame opened
	logic                           cs_rise;        // Frame closed
	logic                           done_evt;       // Full word just arrived
	logic                           apply;          // Execute the held word
	logic                           clr;            // Status clear executed
	hbsc_pkg::hbsc_ctrl_t           ctrl_reg;       // Input register
	logic                           test_mode_reg;  // Reserved word in force
	logic [5:0]                     sc_off_reg;     // Switches cut off by overcurrent
	logic [5:0]                     sw_reg;         // Actual switch states
	logic [5:0]                     sw_next;        // Next switch states
	logic [5:0]                     short_evt;      // Overcurrent on a live switch
	logic                           open_evt;       // Open load on a live switch
	logic                           drive_ok;       // Outputs may conduct
	logic                           short_flag_reg;     // Short-circuit flag
	logic                           open_load_flag_reg; // Open-load flag
	logic                           supply_fail_reg;    // Supply-fail flag
	hbsc_pkg::hbsc_status_t         status_now;     // Live status word
	hbsc_pkg::hbsc_status_t         status_pub_reg; // Output register seen by the link

	// Link side

	// Counters only run while selected; deselect clears them without a clock
	// Hazard: this clear is a gate output, so chip select must be glitch-free
	assign link_clr = cs_n | ~nrst;

	// Next shift value, LSB arrives first so it ends in bit 0
	assign rx_word_next = {serial_in, rx_shift_reg[15:1]};

	// Count sampled bits, saturating after one full word
	always_ff @(negedge sclk or posedge link_clr)
	begin
		if (link_clr)
			rx_cnt_reg <= hbsc_pkg::CNT_ZERO;
		else if (rx_cnt_reg != hbsc_pkg::FRAME_CNT)
			rx_cnt_reg <= rx_cnt_reg + hbsc_pkg::CNT_ONE;
	end

	// Sample the serial input on falling edges of a selected frame
	always_ff @(negedge sclk or negedge nrst)
	begin
		if (!nrst)
			rx_shift_reg <= 16'h0000;
		else if (!cs_n)
			rx_shift_reg <= rx_word_next;
	end

	// Capture the word on the sixteenth bit; extra bits are ignored
	// Held until the next full word; the core reads it only after the toggle crossed
	always_ff @(negedge sclk or negedge nrst)
	begin
		if (!nrst)
		begin
			word_hold_reg <= hbsc_pkg::CTRL_RST;
			done_tgl_reg  <= 1'b0;
		end
		else if (!cs_n && rx_cnt_reg == hbsc_pkg::LAST_CNT)
		begin
			word_hold_reg <= rx_word_next;
			done_tgl_reg  <= ~done_tgl_reg;
		end
	end

	// Count rising edges; the first keeps bit 0, each later one moves on a bit
	always_ff @(posedge sclk or posedge link_clr)
	begin
		if (link_clr)
			tx_cnt_reg <= hbsc_pkg::CNT_ZERO;
		else if (tx_cnt_reg != hbsc_pkg::FRAME_CNT)
			tx_cnt_reg <= tx_cnt_reg + hbsc_pkg::CNT_ONE;
	end

	// Bit 0 shows from the select edge, before any clock
	always_comb
	begin
		if (tx_cnt_reg == hbsc_pkg::CNT_ZERO)
			tx_idx = 4'h0;
		else
			tx_idx = 4'(tx_cnt_reg - hbsc_pkg::CNT_ONE);
	end

	// The published word is frozen during a frame, so it is quasi-static here
	assign serial_out    = status_pub_reg[tx_idx];
	assign serial_out_en = ~cs_n & nrst;

	// Core side

	// All outside levels and the link toggle pass the same synchroniser
	// One shared chain keeps chip select and the toggle in their order of arrival
	assign sync_in = {cs_n, run_enable, done_tgl_reg, thermal_warning_in, uv_in,
		short_in, open_load_in};

	hbsc_sync #(
		.W   (hbsc_pkg::SYNC_W),
		.RST (hbsc_pkg::SYNC_RST)
	) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.din      (sync_in),
		.dout     (sync_q)
	);

	assign cs_q     = sync_q[16];
	assign run_q    = sync_q[15];
	assign done_q   = sync_q[14];
	assign therm_q  = sync_q[13];
	assign uv_raw_q = sync_q[12];
	assign short_q  = sync_q[11:6];
	assign open_q   = sync_q[5:0];

	// Dips shorter than the filter delay never reach the flag or outputs
	hbsc_uv_filter #(
		.DELAY_CYC (UV_FILTER_CYC)
	) u_uv (
		.core_clk (core_clk),
		.nrst     (nrst),
		.clear    (~run_q),
		.uv_raw   (uv_raw_q),
		.uv_qual  (uv_q)
	);

	// Edge history of chip select and the word toggle
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_prev_reg   <= 1'b1;
			done_prev_reg <= 1'b0;
		end
		else
		begin
			cs_prev_reg   <= cs_q;
			done_prev_reg <= done_q;
		end
	end

	assign cs_fall  = cs_prev_reg & ~cs_q;
	assign cs_rise  = ~cs_prev_reg & cs_q;
	assign done_evt = done_q ^ done_prev_reg;

	// Remember a complete word until its frame closes
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			pending_reg <= 1'b0;
		else if (!run_q || cs_fall || cs_rise)
			pending_reg <= 1'b0;
		else if (done_evt)
			pending_reg <= 1'b1;
	end

	// Only a full word executes, and only at the closing edge
	// A toggle that crosses together with the closing edge still counts
	assign apply = run_q & cs_rise & (pending_reg | done_evt);
	assign clr   = apply & word_hold_reg.status_clear;

	// Input register; inhibit holds it at its power-on value
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			ctrl_reg <= hbsc_pkg::CTRL_RST;
		else if (!run_q)
			ctrl_reg <= hbsc_pkg::CTRL_RST;
		else if (apply)
			ctrl_reg <= word_hold_reg;
	end

	// A reserved word parks the switches; the next normal word leaves test mode
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			test_mode_reg <= 1'b0;
		else if (!run_q)
			test_mode_reg <= 1'b0;
		else if (apply)
			test_mode_reg <= is_test_word(word_hold_reg);
	end

	// Outputs conduct only when running, supplied and not in test mode
	assign drive_ok  = run_q & ~uv_q & ~test_mode_reg;
	assign short_evt = short_q & sw_reg;
	assign open_evt  = |(open_q & sw_reg);
	assign sw_next   = ctrl_reg.sw & ~sc_off_reg & {6{drive_ok}};

	// Overcurrent cutoff latches per switch; status clear re-enables them
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			sc_off_reg <= 6'h00;
		else if (!run_q)
			sc_off_reg <= 6'h00;
		else
			sc_off_reg <= (sc_off_reg & ~{6{clr}}) |
				(short_evt & {6{ctrl_reg.overcurrent_cutoff_en}});
	end

	// Actual switch states, registered for the outputs and status
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			sw_reg <= 6'h00;
		else
			sw_reg <= sw_next;
	end

	// Sticky flags; a new event in the clearing cycle wins over the clear
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			short_flag_reg     <= 1'b0;
			open_load_flag_reg <= 1'b0;
			supply_fail_reg    <= 1'b0;
		end
		else if (!run_q)
		begin
			short_flag_reg     <= 1'b0;
			open_load_flag_reg <= 1'b0;
			supply_fail_reg    <= 1'b0;
		end
		else
		begin
			short_flag_reg     <= (short_flag_reg & ~clr) | (|short_evt);
			open_load_flag_reg <= (open_load_flag_reg & ~clr) | open_evt;
			supply_fail_reg    <= (supply_fail_reg & ~clr) | uv_q;
		end
	end

	// Live status word; unused positions read low
	always_comb
	begin
		status_now                  = hbsc_pkg::STATUS_RST;
		status_now.thermal_warning  = therm_q;
		status_now.sw               = sw_reg;
		status_now.short_flag       = short_flag_reg;
		status_now.open_load_flag   = open_load_flag_reg;
		status_now.supply_fail_flag = supply_fail_reg;
	end

	// Output register follows while idle and freezes once the frame opens
	// Trade-off: the freeze lags the pin by the synchroniser, so the host waits
	// before its first clock; in return the link never sees a half-updated word
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			status_pub_reg <= hbsc_pkg::STATUS_RST;
		else if (!run_q)
			status_pub_reg <= hbsc_pkg::STATUS_RST;
		else if (cs_q)
			status_pub_reg <= status_now;
	end

	// Drive the power stage and mode pins
	assign switch_on             = sw_reg;
	assign overcurrent_cutoff_en = ctrl_reg.overcurrent_cutoff_en;
	assign test_mode             = test_mode_reg;

endmodule

// ---- shared/hbsc_pkg.sv ----
package hbsc_pkg;

	// Frame geometry
	localparam int              FRAME_BITS = 16;      // Bits in one control or status word
	localparam int              CNT_W      = 5;       // Width of the link bit counters
	localparam logic [4:0]      CNT_ZERO   = 5'h00;   // Counter value at frame start
	localparam logic [4:0]      CNT_ONE    = 5'h01;   // Counter step
	localparam logic [4:0]      LAST_CNT   = 5'h0F;   // Count before the last sampled bit
	localparam logic [4:0]      FRAME_CNT  = 5'h10;   // Count after a full frame

	// Timing
	localparam int              CLK_PERIOD_NS = 20;     // core_clk period
	localparam int              UV_FILTER_NS  = 10000;  // Undervoltage filter delay, plain default
	localparam int              UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Values after reset
	localparam logic [15:0]     CTRL_RST   = 16'h2000;  // Cutoff enabled, all switches off
	localparam logic [15:0]     STATUS_RST = 16'h0000;  // Erased output register

	// Reserved words that select internal test modes
	localparam logic [15:0]     TEST_PAT_A = 16'hF800;
	localparam logic [15:0]     TEST_PAT_B = 16'hE600;
	localparam logic [15:0]     TEST_PAT_C = 16'hE180;

	// Synchroniser reset image: {cs_n, run_enable, toggle, thermal, uv, short[5:0], open[5:0]}
	localparam int              SYNC_W   = 17;
	localparam logic [16:0]     SYNC_RST = 17'h10000;

	// Six switches in word order, bit 1 (low_switch_1) at the right
	typedef struct packed {
		logic high_switch_3;
		logic low_switch_3;
		logic high_switch_2;
		logic low_switch_2;
		logic high_switch_1;
		logic low_switch_1;
	} hbsc_switch_t;

	// Control word, bit 15 at the left
	typedef struct packed {
		logic [1:0]   spare_hi;
		logic         overcurrent_cutoff_en;
		logic [5:0]   spare_mid;
		hbsc_switch_t sw;
		logic         status_clear;
	} hbsc_ctrl_t;

	// Status word, bit 15 at the left
	typedef struct packed {
		logic         supply_fail_flag;
		logic         open_load_flag;
		logic         short_flag;
		logic [5:0]   spare;
		hbsc_switch_t sw;
		logic         thermal_warning;
	} hbsc_status_t;

endpackage

// ---- verilog/hbsc_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; a bit changes once stages two and three agree
module hbsc_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] s1_reg;  // Metastable stage, read only by s2_reg
	logic [W-1:0] s2_reg;  // Second stage
	logic [W-1:0] s3_reg;  // Third stage
	logic [W-1:0] q_reg;   // Agreed value

	generate
		if (W < 1)
		begin : g_bad_width
			$error("hbsc_sync: width must be at least one");
		end
	endgenerate

	// Shift chain
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_reg <= RST;
			s2_reg <= RST;
			s3_reg <= RST;
		end
		else
		begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Take a bit only where the two settled stages agree; filters one-cycle glitches
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			q_reg <= RST;
		else
			q_reg <= (q_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
	end

	assign dout = q_reg;

endmodule

// ---- verilog/hbsc_uv_filter.sv ----
`timescale 1ns/1ps
// Persistence filter for the supply undervoltage level
module hbsc_uv_filter #(
	parameter int DELAY_CYC = hbsc_pkg::UV_FILTER_CYC
) (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic clear,     // Internal power-on reset
	input  wire logic uv_raw,    // Synchronised undervoltage level
	output logic      uv_qual    // Undervoltage accepted
);

	localparam int CW = $clog2(DELAY_CYC + 1);

	logic [CW-1:0] cnt_reg;   // Cycles the dip has lasted
	logic          qual_reg;  // Qualified level

	generate
		if (DELAY_CYC < 1)
		begin : g_bad_delay
			$error("hbsc_uv_filter: delay must be at least one cycle");
		end
	endgenerate

	// Count while low supply persists; any return resets the count
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_reg <= '0;
		else if (clear || !uv_raw)
			cnt_reg <= '0;
		else if (cnt_reg != CW'(DELAY_CYC))
			cnt_reg <= cnt_reg + CW'(1);
	end

	// Accept only after the full delay; drop at once on recovery
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			qual_reg <= 1'b0;
		else
			qual_reg <= uv_raw && !clear && (cnt_reg == CW'(DELAY_CYC));
	end

	assign uv_qual = qual_reg;

endmodule

// ---- tb/hbsc_host.sv ----
`timescale 1ns/1ps
// Serial master model; the link clock stands still between frames
module hbsc_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      serial_in,
	input  wire logic so_pin
);
	// Idle lines: deselected, clock parked low
	initial
	begin
		sclk      = 1'b0;
		cs_n      = 1'b1;
		serial_in = 1'b0;
	end

	// One frame of nb bits; data moves mid-low so the falling edge never races it
	task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] st);
		st = 16'h0000;
		// Step off the core clock edge so chip select never races the synchroniser
		#3;
		cs_n = 1'b0;
		#100;
		for (int k = 0; k < nb; k++)
		begin
			#3.75 serial_in = w[k];
			#3.75 sclk = 1'b1;
			#7.5 st[k] = so_pin;
			sclk = 1'b0;
		end
		#60 cs_n = 1'b1;
		serial_in = 1'b0; // Data line driven low between frames
		#120;
	endtask
endmodule

// ---- tb/hbsc_serial_ctrl_props.sv ----
`timescale 1ns/1ps
// Port-level checks of the serial control block
module hbsc_serial_ctrl_props #(
	parameter int UV_FILTER_CYC = hbsc_pkg::UV_FILTER_CYC
) (
	input wire logic                   core_clk,
	input wire logic                   nrst,
	input wire logic                   sclk,
	input wire logic                   cs_n,
	input wire logic                   serial_in,
	input wire logic                   serial_out,
	input wire logic                   serial_out_en,
	input wire logic                   run_enable,
	input wire logic                   thermal_warning_in,
	input wire logic                   uv_in,
	input wire hbsc_pkg::hbsc_switch_t short_in,
	input wire hbsc_pkg::hbsc_switch_t open_load_in,
	input wire hbsc_pkg::hbsc_switch_t switch_on,
	input wire logic                   overcurrent_cutoff_en,
	input wire logic                   test_mode
);
	logic [11:0] uv_cnt;  // Run length of a raised undervoltage pin
	logic [3:0]  therm_cnt;  // Cycles thermal held still while run-enable is high
	logic        so_neg;  // Serial output at the last falling link edge
	logic        seen;    // A falling link edge occurred in this frame
	logic        quiet;   // Selected, running, no supply dip and no short

	assign quiet = !cs_n && run_enable && !uv_in && short_in == 6'h00;

	// Saturates so a long dip never wraps back to zero
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			uv_cnt <= 12'h000;
		else if (!uv_in)
			uv_cnt <= 12'h000;
		else if (uv_cnt != 12'hFFF)
			uv_cnt <= uv_cnt + 12'h001;
	end

	// The synchroniser needs time before bit 0 may follow the pin
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			therm_cnt <= 4'h0;
		else if (!run_enable || $changed(thermal_warning_in))
			therm_cnt <= 4'h0;
		else if (therm_cnt != 4'hF)
			therm_cnt <= therm_cnt + 4'h1;
	end

	// Capture at falling edges; deselect forgets the capture
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
			seen <= 1'b0;
		else
			seen <= 1'b1;
	end

	// Value to compare at the next rising edge
	always_ff @(negedge sclk)
	begin
		so_neg <= serial_out;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	oe_follows_cs_a: assert property (serial_out_en == !cs_n)
		else $error("output enable does not follow chip select");
	inhibit_clears_a: assert property ((!run_enable)[*8] |-> switch_on == 6'h00 && !test_mode)
		else $error("inhibit left switches or test mode active");
	run_rise_reset_a: assert property ((!run_enable)[*6] ##1 run_enable |-> overcurrent_cutoff_en)
		else $error("cutoff not enabled after internal reset");
	ctrl_hold_sel_a: assert property ((!cs_n && run_enable)[*3] |-> $stable(overcurrent_cutoff_en) && $stable(test_mode))
		else $error("control changed during a frame");
	test_word_off_a: assert property (test_mode && $past(test_mode) |-> switch_on == 6'h00 && overcurrent_cutoff_en)
		else $error("test word left a switch closed");
	uv_outputs_off_a: assert property (uv_cnt > UV_FILTER_CYC + 10 |-> switch_on == 6'h00)
		else $error("outputs kept during long undervoltage");
	first_bit_therm_a: assert property ($fell(cs_n) && therm_cnt == 4'hF |-> ##2 serial_out == thermal_warning_in)
		else $error("first status bit is not the thermal level");
	sel_sw_stable_a: assert property (quiet[*8] ##1 quiet[*8] |-> $stable(switch_on))
		else $error("switches moved during a frame");
	so_steady_a: assert property (@(posedge sclk) disable iff (!nrst) seen |-> serial_out == so_neg)
		else $error("serial output moved between rising edges");

	test_cov: cover property (test_mode);
	uv_cov: cover property (uv_cnt > UV_FILTER_CYC + 10);
	therm_cov: cover property ($fell(cs_n) && therm_cnt == 4'hF && thermal_warning_in);
endmodule

bind hbsc_serial_ctrl hbsc_serial_ctrl_props #(.UV_FILTER_CYC(UV_FILTER_CYC)) u_hbsc_serial_ctrl_props (
	.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
	.serial_out(serial_out), .serial_out_en(serial_out_en), .run_enable(run_enable),
	.thermal_warning_in(thermal_warning_in), .uv_in(uv_in), .short_in(short_in),
	.open_load_in(open_load_in), .switch_on(switch_on), .overcurrent_cutoff_en(overcurrent_cutoff_en),
	.test_mode(test_mode)
);

// ---- tb/hbsc_serial_ctrl_test.sv ----
`timescale 1ns/1ps
// Self-checking bench: table of control words, then the protection cases
module hbsc_serial_ctrl_test;
	// Word sent and the state it should leave
	typedef struct packed {
		logic [15:0]            word;
		hbsc_pkg::hbsc_switch_t sw;
		logic                   cut;
		logic                   tm;
	} hbsc_row_t;

	logic                   core_clk, nrst, run_enable;       // Clock, reset, inhibit pin
	logic                   thermal_warning_in, uv_in;        // Condition pins
	hbsc_pkg::hbsc_switch_t short_in, open_load_in, switch_on; // Per-switch levels
	logic                   overcurrent_cutoff_en, test_mode; // Control outputs
	logic                   sclk, cs_n, serial_in, serial_out, serial_out_en;
	wire                    so_pin;                           // Resolved serial output line
	logic [15:0]            last_st;                          // Status from the last frame
	hbsc_pkg::hbsc_switch_t prev_sw;                          // Switches the next status shows
	int                     n_mismatch, n_compared;
	hbsc_row_t              rows [12] = '{
		'{16'h2002, 6'h01, 1'b1, 1'b0}, '{16'h2004, 6'h02, 1'b1, 1'b0}, '{16'h2008, 6'h04, 1'b1, 1'b0},
		'{16'h2010, 6'h08, 1'b1, 1'b0}, '{16'h2020, 6'h10, 1'b1, 1'b0}, '{16'h2040, 6'h20, 1'b1, 1'b0},
		'{16'h007E, 6'h3F, 1'b0, 1'b0}, '{16'hF800, 6'h00, 1'b1, 1'b1}, '{16'hDF80, 6'h00, 1'b0, 1'b0},
		'{16'hE600, 6'h00, 1'b1, 1'b1}, '{16'hE180, 6'h00, 1'b1, 1'b1}, '{16'h2000, 6'h00, 1'b1, 1'b0}};

	assign so_pin = serial_out_en ? serial_out : 1'bz;

	hbsc_serial_ctrl #(.UV_FILTER_CYC(4)) u_hbsc_serial_ctrl (
		.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en), .run_enable(run_enable),
		.thermal_warning_in(thermal_warning_in), .uv_in(uv_in), .short_in(short_in),
		.open_load_in(open_load_in), .switch_on(switch_on), .overcurrent_cutoff_en(overcurrent_cutoff_en),
		.test_mode(test_mode));

	hbsc_host u_hbsc_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .so_pin(so_pin));

	// Core clock
	always #(hbsc_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

	function automatic logic [15:0] mk_status(logic [2:0] f, logic [5:0] s, logic t);
		return {f, 6'h00, s, t};
	endfunction

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic chk_sw(input string nm, input logic [5:0] e, input logic [5:0] g);
		chk_word(nm, {10'h000, e}, {10'h000, g});
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {15'h0000, e}, {15'h0000, g});
	endtask

	// Frame, then enough core cycles for the word to take effect
	task automatic frame(input logic [15:0] w, input int nb);
		u_hbsc_host.xfer(w, nb, last_st);
		wait_cyc(6);
	endtask

	// Set the condition pins at a clock edge and hold them n cycles
	task automatic pins(input logic [5:0] sh, input logic [5:0] ol, input logic th, input logic uv, input int n);
		short_in           <= sh;
		open_load_in       <= ol;
		thermal_warning_in <= th;
		uv_in              <= uv;
		wait_cyc(n);
	endtask

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		nrst = 1'b0;
		run_enable = 1'b1;
		n_mismatch = 0;
		n_compared = 0;
		pins(6'h00, 6'h00, 1'b0, 1'b0, 2);
		nrst <= 1'b1;
		wait_cyc(8);
		chk_sw("switch_on", 6'h00, switch_on);
		chk_bit("cutoff", 1'b1, overcurrent_cutoff_en);
		prev_sw = 6'h00;
		foreach (rows[i])
		begin
			frame(rows[i].word, 16);
			chk_word("status", mk_status(3'h0, prev_sw, 1'b0), last_st);
			chk_sw("switch_on", rows[i].sw, switch_on);
			chk_bit("cutoff", rows[i].cut, overcurrent_cutoff_en);
			chk_bit("test_mode", rows[i].tm, test_mode);
			prev_sw = rows[i].sw;
		end
		// Abandoned frame still returns its first bits
		frame(16'h2006, 16);
		frame(16'h0000, 8);
		chk_word("partial status", 16'h0006, last_st);
		chk_sw("switch_on", 6'h03, switch_on);
		// Overcurrent with cutoff enabled latches the switch open
		pins(6'h01, 6'h00, 1'b0, 1'b0, 10);
		pins(6'h00, 6'h00, 1'b0, 1'b0, 10);
		chk_sw("switch_on", 6'h02, switch_on);
		frame(16'h2006, 16);
		chk_word("status", mk_status(3'h1, 6'h02, 1'b0), last_st);
		frame(16'h2007, 16);
		chk_sw("switch_on", 6'h03, switch_on);
		frame(16'h0006, 16);
		chk_word("status", mk_status(3'h0, 6'h03, 1'b0), last_st);
		// Cutoff disabled: overcurrent only flags; thermal and open load ride along
		pins(6'h01, 6'h02, 1'b1, 1'b0, 10);
		pins(6'h00, 6'h00, 1'b1, 1'b0, 10);
		chk_sw("switch_on", 6'h03, switch_on);
		frame(16'h0007, 16);
		chk_word("status", mk_status(3'h3, 6'h03, 1'b1), last_st);
		pins(6'h00, 6'h00, 1'b0, 1'b0, 10);
		frame(16'h0006, 16);
		chk_word("status", mk_status(3'h0, 6'h03, 1'b0), last_st);
		// Brief dip ignored, long dip opens all switches until recovery
		pins(6'h00, 6'h00, 1'b0, 1'b1, 2);
		pins(6'h00, 6'h00, 1'b0, 1'b0, 12);
		chk_sw("switch_on", 6'h03, switch_on);
		pins(6'h00, 6'h00, 1'b0, 1'b1, 20);
		chk_sw("switch_on", 6'h00, switch_on);
		pins(6'h00, 6'h00, 1'b0, 1'b0, 10);
		chk_sw("switch_on", 6'h03, switch_on);
		frame(16'h0006, 16);
		chk_word("status", mk_status(3'h4, 6'h03, 1'b0), last_st);
		// Inhibit erases the latched flag and restores reset control
		run_enable <= 1'b0;
		wait_cyc(10);
		chk_sw("switch_on", 6'h00, switch_on);
		chk_bit("cutoff", 1'b1, overcurrent_cutoff_en);
		run_enable <= 1'b1;
		wait_cyc(10);
		frame(16'h2000, 16);
		chk_word("status", mk_status(3'h0, 6'h00, 1'b0), last_st);
		end_sim();
	end

	// Hang guard
	initial
	begin
		wait_cyc(20000);
		n_mismatch++;
		end_sim();
	end
endmodule
